// ---- design/twc_timer.sv ----
// twc_timer: 8-bit timer/counter with two compare outputs, wishbone register access.
// assumes a classic wishbone master on clk_i; pin enables go to the port mux outside.
//
// Our own choices: the register addresses and the Wishbone register port.
`timescale 1ns/10ps

module twc_timer (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [twc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [twc_pkg::DAT_W-1:0] wb_dat_i,
   output logic [twc_pkg::DAT_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   output logic compare_output_a_pin_o,
   output logic compare_output_a_pin_en_o,
   output logic compare_output_b_pin_o,
   output logic compare_output_b_pin_en_o,
   output logic irq_o
);
   import twc_pkg::*;

   // ---------------- registers ----------------
   logic [7:0] timer_waveform_control_a;
   logic [7:0] timer_clock_control_b;
   logic [CNT_W-1:0] counter_value;
   logic [CNT_W-1:0] compare_value_a_buf;
   logic [CNT_W-1:0] compare_value_b_buf;
   logic [CNT_W-1:0] compare_value_a;
   logic [CNT_W-1:0] compare_value_b;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic counting_up;
   logic match_blocked;
   logic tick;

   // ---------------- mode decode ----------------
   function automatic logic mode_top_from_a(input logic [2:0] m);
      return (m == MODE_CLEAR_ON_MATCH) || (m == MODE_PC_CMPA) || (m == MODE_FAST_CMPA);
   endfunction

   function automatic logic mode_is_fast(input logic [2:0] m);
      return (m == MODE_FAST_FF) || (m == MODE_FAST_CMPA);
   endfunction

   function automatic logic mode_is_phase(input logic [2:0] m);
      return (m == MODE_PC_FF) || (m == MODE_PC_CMPA);
   endfunction

   wire logic [1:0] channel_a_output_action = timer_waveform_control_a[CA_ACT_A_LSB +: 2];
   wire logic [1:0] channel_b_output_action = timer_waveform_control_a[CA_ACT_B_LSB +: 2];
   wire logic waveform_mode_top_bit = timer_clock_control_b[CB_TOP_BIT];
   wire logic [2:0] waveform_mode_select =
      {waveform_mode_top_bit, timer_waveform_control_a[CA_MODE_LSB +: 2]};
   wire logic [2:0] clock_select = timer_clock_control_b[CB_CSEL_LSB +: 3];

   // reserved codes 4 and 6 count as normal mode but raise no overflow flag; outputs follow non-PWM actions
   wire logic fast_mode = mode_is_fast(waveform_mode_select);
   wire logic phase_mode = mode_is_phase(waveform_mode_select);
   wire logic pwm_mode = fast_mode | phase_mode;
   wire logic [CNT_W-1:0] top_value =
      mode_top_from_a(waveform_mode_select) ? compare_value_a : CNT_MAX;

   // ---------------- bus decode ----------------
   wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire logic bus_wr = bus_req & wb_we_i & wb_sel_i[0];
   wire logic [7:0] wr_byte = wb_dat_i[7:0];
   wire logic wr_ctrl_a = bus_wr & (wb_adr_i == OFS_CTRL_A);
   wire logic wr_ctrl_b = bus_wr & (wb_adr_i == OFS_CTRL_B);
   wire logic wr_count = bus_wr & (wb_adr_i == OFS_COUNT);
   wire logic wr_cmp_a = bus_wr & (wb_adr_i == OFS_CMP_A);
   wire logic wr_cmp_b = bus_wr & (wb_adr_i == OFS_CMP_B);
   wire logic wr_status = bus_wr & (wb_adr_i == OFS_IRQ_STATUS);
   wire logic wr_mask = bus_wr & (wb_adr_i == OFS_IRQ_MASK);

   logic [7:0] rd_byte;

   always_comb begin
      rd_byte = 8'h00;
      unique case (wb_adr_i)
         OFS_CTRL_A: rd_byte = timer_waveform_control_a & CA_WRITE_MASK;
         OFS_CTRL_B: rd_byte = timer_clock_control_b & CB_WRITE_MASK;
         OFS_COUNT: rd_byte = counter_value;
         OFS_CMP_A: rd_byte = compare_value_a_buf;
         OFS_CMP_B: rd_byte = compare_value_b_buf;
         OFS_IRQ_STATUS: rd_byte = {5'h00, irq_status};
         OFS_IRQ_MASK: rd_byte = {5'h00, irq_mask};
         default: rd_byte = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= '0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= bus_req ? {24'h000000, rd_byte} : '0;
      end
   end

   // ---------------- control registers ----------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timer_waveform_control_a <= RST_CTRL;
         timer_clock_control_b <= RST_CTRL;
         irq_mask <= RST_IRQ;
      end else begin
         if (wr_ctrl_a) begin
            timer_waveform_control_a <= wr_byte & CA_WRITE_MASK;
         end
         if (wr_ctrl_b) begin
            timer_clock_control_b <= wr_byte & CB_WRITE_MASK;
         end
         if (wr_mask) begin
            irq_mask <= wr_byte[IRQ_W-1:0];
         end
      end
   end

   // ---------------- counter ----------------
   twc_prescaler u_prescaler (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .csel_i(clock_select),
      .tick_o(tick)
   );

   wire logic at_top = counter_value == top_value;
   wire logic at_bottom = counter_value == CNT_BOTTOM;
   wire logic [CNT_W-1:0] count_inc = counter_value + 8'h01;
   wire logic [CNT_W-1:0] count_dec = counter_value - 8'h01;
   logic [CNT_W-1:0] next_counter;
   logic next_up;

   always_comb begin
      next_counter = counter_value;
      next_up = counting_up;
      if (phase_mode) begin
         // dual slope: stays at top one tick, turns at top and at bottom
         if (top_value == CNT_BOTTOM) begin
            next_counter = CNT_BOTTOM;
            next_up = 1'b1;
         end else if (counting_up) begin
            next_counter = at_top ? count_dec : count_inc;
            next_up = ~at_top;
         end else begin
            next_counter = at_bottom ? count_inc : count_dec;
            next_up = at_bottom;
         end
      end else begin
         next_counter = at_top ? CNT_BOTTOM : count_inc;
         next_up = 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_value <= RST_COUNT;
         counting_up <= 1'b1;
         match_blocked <= 1'b0;
      end else if (wr_count) begin
         // a counter write suppresses the compare match on the next tick
         counter_value <= wr_byte;
         match_blocked <= 1'b1;
      end else if (tick) begin
         counter_value <= next_counter;
         counting_up <= next_up;
         match_blocked <= 1'b0;
      end
   end

   // ---------------- compare values ----------------
   wire logic top_tick = tick & at_top;
   wire logic load_cmp = ~pwm_mode | top_tick;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         compare_value_a_buf <= RST_CMP;
         compare_value_b_buf <= RST_CMP;
         compare_value_a <= RST_CMP;
         compare_value_b <= RST_CMP;
      end else begin
         if (wr_cmp_a) begin
            compare_value_a_buf <= wr_byte;
         end
         if (wr_cmp_b) begin
            compare_value_b_buf <= wr_byte;
         end
         if (load_cmp) begin
            compare_value_a <= compare_value_a_buf;
            compare_value_b <= compare_value_b_buf;
         end
      end
   end

   // ---------------- events and interrupt ----------------
   wire logic match_a = tick & ~match_blocked & (counter_value == compare_value_a);
   wire logic match_b = tick & ~match_blocked & (counter_value == compare_value_b);
   wire logic ovf_at_max = tick & (counter_value == CNT_MAX) &
      ((waveform_mode_select == MODE_NORMAL) || (waveform_mode_select == MODE_CLEAR_ON_MATCH) ||
       (waveform_mode_select == MODE_FAST_FF));
   wire logic ovf_at_bottom = tick & phase_mode & at_bottom & ~counting_up;
   wire logic ovf_at_top = tick & at_top & (waveform_mode_select == MODE_FAST_CMPA);
   wire logic [IRQ_W-1:0] irq_events = {match_b, match_a, ovf_at_max | ovf_at_bottom | ovf_at_top};
   wire logic [IRQ_W-1:0] irq_clear = wr_status ? wr_byte[IRQ_W-1:0] : RST_IRQ;
   // a set arriving with its clear wins
   wire logic [IRQ_W-1:0] next_irq_status = (irq_status & ~irq_clear) | irq_events;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_status <= RST_IRQ;
         irq_o <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         irq_o <= |(irq_status & irq_mask);
      end
   end

   // ---------------- compare outputs ----------------
   wire twc_wave_t wave_ctl = '{
      fast: fast_mode,
      phase: phase_mode,
      counting_up: counting_up,
      top_bit: waveform_mode_top_bit,
      at_top: top_tick
   };

   twc_channel #(
      .TOGGLE_IN_PWM(1'b1)
   ) u_channel_a (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ctl_i(wave_ctl),
      .action_i(channel_a_output_action),
      .match_i(match_a),
      .cmp_is_top_i(compare_value_a == top_value),
      .pin_o(compare_output_a_pin_o),
      .pin_en_o(compare_output_a_pin_en_o)
   );

   twc_channel #(
      .TOGGLE_IN_PWM(1'b0)
   ) u_channel_b (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .ctl_i(wave_ctl),
      .action_i(channel_b_output_action),
      .match_i(match_b),
      .cmp_is_top_i(compare_value_b == top_value),
      .pin_o(compare_output_b_pin_o),
      .pin_en_o(compare_output_b_pin_en_o)
   );

   // the pin direction bit stays with software; pin_en only requests the port override

endmodule

// ---- design/twc_pkg.sv ----
// twc_pkg: shared constants, types and register map of the 8-bit timer waveform unit.
// assumes a 32-bit classic wishbone slave with word-aligned byte addresses.
package twc_pkg;

   localparam int CNT_W = 8;
   localparam int ADR_W = 8;
   localparam int DAT_W = 32;
   localparam int PRE_W = 10;

   // register byte offsets
   localparam logic [ADR_W-1:0] OFS_CTRL_A = 8'h00;
   localparam logic [ADR_W-1:0] OFS_CTRL_B = 8'h04;
   localparam logic [ADR_W-1:0] OFS_COUNT = 8'h08;
   localparam logic [ADR_W-1:0] OFS_CMP_A = 8'h0c;
   localparam logic [ADR_W-1:0] OFS_CMP_B = 8'h10;
   localparam logic [ADR_W-1:0] OFS_IRQ_STATUS = 8'h14;
   localparam logic [ADR_W-1:0] OFS_IRQ_MASK = 8'h18;

   // timer_waveform_control_a fields
   localparam int CA_ACT_A_LSB = 6;
   localparam int CA_ACT_B_LSB = 4;
   localparam int CA_MODE_LSB = 0;
   localparam logic [7:0] CA_WRITE_MASK = 8'hf3;

   // timer_clock_control_b fields
   localparam int CB_TOP_BIT = 3;
   localparam int CB_CSEL_LSB = 0;
   localparam logic [7:0] CB_WRITE_MASK = 8'h0f;

   // interrupt status and mask bits
   localparam int IRQ_OVF = 0;
   localparam int IRQ_MATCH_A = 1;
   localparam int IRQ_MATCH_B = 2;
   localparam int IRQ_W = 3;

   localparam logic [7:0] RST_CTRL = 8'h00;
   localparam logic [CNT_W-1:0] RST_COUNT = 8'h00;
   localparam logic [CNT_W-1:0] RST_CMP = 8'h00;
   localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
   localparam logic [CNT_W-1:0] CNT_MAX = 8'hff;
   localparam logic [CNT_W-1:0] CNT_BOTTOM = 8'h00;

   // prescaler divide masks, tick when the low bits are all ones
   localparam logic [PRE_W-1:0] DIV1_MASK = 10'h000;
   localparam logic [PRE_W-1:0] DIV8_MASK = 10'h007;
   localparam logic [PRE_W-1:0] DIV64_MASK = 10'h03f;
   localparam logic [PRE_W-1:0] DIV256_MASK = 10'h0ff;
   localparam logic [PRE_W-1:0] DIV1024_MASK = 10'h3ff;

   typedef enum logic [2:0] {
      MODE_NORMAL = 3'h0,
      MODE_PC_FF = 3'h1,
      MODE_CLEAR_ON_MATCH = 3'h2,
      MODE_FAST_FF = 3'h3,
      MODE_RSVD4 = 3'h4,
      MODE_PC_CMPA = 3'h5,
      MODE_RSVD6 = 3'h6,
      MODE_FAST_CMPA = 3'h7
   } twc_mode_t;

   // timing strobes and mode class passed to each compare channel
   typedef struct packed {
      logic fast;
      logic phase;
      logic counting_up;
      logic top_bit;
      logic at_top;
   } twc_wave_t;

endpackage

// ---- design/twc_prescaler.sv ----
// twc_prescaler: free-running divider giving the timer count enable.
// assumes clk_i is the i/o clock; select codes 0, 6 and 7 hold the timer stopped.
`timescale 1ns/10ps
module twc_prescaler (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [2:0] csel_i,
   output logic tick_o
);
   import twc_pkg::*;

   logic [PRE_W-1:0] div_cnt;
   logic [PRE_W-1:0] div_mask;
   logic run;
   wire logic [PRE_W-1:0] next_div_cnt = div_cnt + 10'h001;
   wire logic div_hit = (div_cnt & div_mask) == div_mask;

   always_comb begin
      div_mask = DIV1_MASK;
      run = 1'b1;
      unique case (csel_i)
         3'h1: div_mask = DIV1_MASK;
         3'h2: div_mask = DIV8_MASK;
         3'h3: div_mask = DIV64_MASK;
         3'h4: div_mask = DIV256_MASK;
         3'h5: div_mask = DIV1024_MASK;
         default: run = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_cnt <= '0;
         tick_o <= 1'b0;
      end else begin
         div_cnt <= next_div_cnt;
         tick_o <= run & div_hit;
      end
   end
endmodule

// ---- design/twc_channel.sv ----
// twc_channel: one compare output, applying the two-bit action field per mode.
// assumes match_i and ctl_i.at_top are single-cycle strobes on a timer tick.
`timescale 1ns/10ps
module twc_channel #(
   parameter bit TOGGLE_IN_PWM = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input twc_pkg::twc_wave_t ctl_i,
   input wire logic [1:0] action_i,
   input wire logic match_i,
   input wire logic cmp_is_top_i,
   output logic pin_o,
   output logic pin_en_o
);
   import twc_pkg::*;

   wire logic pwm = ctl_i.fast | ctl_i.phase;
   // in PWM modes a match at top is dropped when the upper action bit is set
   wire logic eff_match = match_i & ~(pwm & action_i[1] & cmp_is_top_i);
   wire logic toggle_ok = ~pwm | (TOGGLE_IN_PWM & ctl_i.top_bit);
   wire logic top_event = pwm & action_i[1] & ctl_i.at_top & (ctl_i.fast | cmp_is_top_i);
   logic next_pin;

   always_comb begin
      next_pin = pin_o;
      if (eff_match) begin
         unique case (action_i)
            2'b01: next_pin = toggle_ok ? ~pin_o : pin_o;
            2'b10: next_pin = ctl_i.phase ? ~ctl_i.counting_up : 1'b0;
            2'b11: next_pin = ctl_i.phase ? ctl_i.counting_up : 1'b1;
            default: next_pin = pin_o;
         endcase
      end else if (top_event) begin
         // fast: set/clear at top; phase correct with compare at top: level of a down-count match
         next_pin = ~action_i[0];
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pin_o <= 1'b0;
         pin_en_o <= 1'b0;
      end else begin
         pin_o <= next_pin;
         pin_en_o <= |action_i;
      end
   end
endmodule

// ---- verif/twc_timer_properties.sv ----
// twc_chk: bus handshake, read data, pin-enable and interrupt-mask properties of the timer waveform unit.
// assumes it is bound into twc_timer and sees only that module's ports.
`timescale 1ns/10ps
module twc_chk import twc_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [twc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [twc_pkg::DAT_W-1:0] wb_dat_i,
   input wire logic [twc_pkg::DAT_W-1:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic compare_output_a_pin_o,
   input wire logic compare_output_a_pin_en_o,
   input wire logic compare_output_b_pin_o,
   input wire logic compare_output_b_pin_en_o,
   input wire logic irq_o
);
   logic taken, wr_taken, act_a_on, act_b_on;
   assign taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_taken = taken && wb_we_i && wb_sel_i[0];
   assign act_a_on = wb_dat_i[7:6] != 2'b00;
   assign act_b_on = wb_dat_i[5:4] != 2'b00;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   chk_ack_follows: assert property (taken |=> wb_ack_o)
      else $error("request not acknowledged in the next cycle");
   chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_cause: assert property (wb_ack_o |-> $past(taken))
      else $error("ack without a taken request");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   chk_dat_upper: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   chk_rsvd_read_zero: assert property (
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == OFS_CTRL_A |-> wb_dat_o[3:2] == 2'b00)
      else $error("control a reserved bits read nonzero");
   chk_pin_en_a: assert property (
      wr_taken && wb_adr_i == OFS_CTRL_A |-> ##2 compare_output_a_pin_en_o == $past(act_a_on, 2))
      else $error("channel a pin enable does not follow action field");
   chk_pin_en_b: assert property (
      wr_taken && wb_adr_i == OFS_CTRL_A |-> ##2 compare_output_b_pin_en_o == $past(act_b_on, 2))
      else $error("channel b pin enable does not follow action field");
   chk_mask_off: assert property (
      wr_taken && wb_adr_i == OFS_IRQ_MASK && wb_dat_i[2:0] == 3'h0 |-> ##2 !irq_o)
      else $error("interrupt high with all sources masked");
endmodule

bind twc_timer twc_chk u_twc_chk (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .compare_output_a_pin_o(compare_output_a_pin_o),
   .compare_output_a_pin_en_o(compare_output_a_pin_en_o), .compare_output_b_pin_o(compare_output_b_pin_o),
   .compare_output_b_pin_en_o(compare_output_b_pin_en_o), .irq_o(irq_o)
);

// ---- verif/tb_twc_timer.sv ----
// tb_twc_timer: self-checking bench for the timer waveform unit.
// assumes one timer tick per clock with clock select 1; bus waits end only by the watchdog.
`timescale 1ns/10ps
module tb_twc_timer;
   import twc_pkg::*;
   logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pa, pa_en, pb, pb_en, irq_o;
   logic [ADR_W-1:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [DAT_W-1:0] wb_dat_i, wb_dat_o;
   logic [15:0] rd_q[$];
   logic [9:0] lv_q[$];
   logic [15:0] rn;
   logic [9:0] ln;
   logic [7:0] d;
   logic [1:0] act_tab [5] = '{2'h0, 2'h3, 2'h2, 2'h1, 2'h1};
   logic lvl_tab [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
   logic [7:0] ofs_tab [7] = '{OFS_CTRL_A, OFS_CTRL_B, OFS_COUNT, OFS_CMP_A, OFS_CMP_B, OFS_IRQ_STATUS, OFS_IRQ_MASK};
   int n_mismatch = 0, samples_checked = 0, seed = 32'h6b14515f, i;
   twc_timer dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .compare_output_a_pin_o(pa), .compare_output_a_pin_en_o(pa_en), .compare_output_b_pin_o(pb),
      .compare_output_b_pin_en_o(pb_en), .irq_o(irq_o));
   initial begin
      clk_i = 1'b0;
      forever #10 clk_i = ~clk_i;
   end
   // zero mask means write, otherwise a read expecting dt under mask m
   task automatic wb(input logic [7:0] a, input logic [7:0] dt, input logic [7:0] m);
      if (m != 8'h00) rd_q.push_back({m, dt});
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= (m == 8'h00);
      wb_adr_i <= a;
      wb_dat_i <= {24'h0, dt};
      do begin
         @(posedge clk_i);
      end while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
      @(posedge clk_i);
   endtask
   // levels are {irq, en b, pin b, en a, pin a}
   task automatic look(input logic [4:0] e, input logic [4:0] m);
      lv_q.push_back({m, e});
      @(posedge clk_i);
   endtask
   task automatic chk_rd(input logic [7:0] e, input logic [7:0] s);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD read data expected %h seen %h", e, s);
      end
   endtask
   task automatic chk_lv(input logic [4:0] e, input logic [4:0] s);
      samples_checked++;
      if (s !== e) begin
         n_mismatch++;
         $display("BAD output levels expected %b seen %b", e, s);
      end
   endtask
   task automatic end_sim();
      $display("compared %0d, mismatched %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // compared at the falling edge, where outputs have settled and no note is pushed
   always @(negedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rd_q.size() > 0) begin
         rn = rd_q.pop_front();
         chk_rd(rn[7:0], wb_dat_o[7:0] & rn[15:8]);
      end
      if (lv_q.size() > 0) begin
         ln = lv_q.pop_front();
         chk_lv(ln[4:0], {irq_o, pb_en, pb, pa_en, pa} & ln[9:5]);
      end
   end
   initial begin
      repeat (6000) @(posedge clk_i);
      n_mismatch++;
      $display("BAD watchdog expected end seen hang");
      end_sim();
   end
   initial begin
      rst_i = 1'b1;
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0;
      repeat (12) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (ofs_tab[k]) wb(ofs_tab[k], 8'h00, 8'hff);
      wb(8'h1c, 8'h5a, 8'h00);
      wb(8'h1c, 8'h00, 8'hff);
      for (i = 0; i < 8; i++) begin
         d = 8'($random(seed));
         wb(OFS_CTRL_A, d, 8'h00);
         wb(OFS_CTRL_A, d & 8'hf3, 8'hff);
         wb(OFS_CTRL_B, d, 8'h00);
         wb(OFS_CTRL_B, d & 8'h0f, 8'hff);
         wb(OFS_CMP_B, d, 8'h00);
         wb(OFS_CMP_B, d, 8'hff);
      end
      $display("test registers done");
      wb(OFS_CTRL_A, 8'h00, 8'h00);
      wb(OFS_CMP_A, 8'h10, 8'h00);
      wb(OFS_CMP_B, 8'h10, 8'h00);
      for (i = 0; i < 5; i++) begin
         wb(OFS_CTRL_B, 8'h00, 8'h00);
         wb(OFS_COUNT, 8'h00, 8'h00);
         wb(OFS_CTRL_A, {act_tab[i], act_tab[i], 4'h0}, 8'h00);
         wb(OFS_CTRL_B, 8'h01, 8'h00);
         repeat (32) @(posedge clk_i);
         look({1'b0, act_tab[i] != 0, lvl_tab[i], act_tab[i] != 0, lvl_tab[i]}, (i == 0) ? 5'h0a : 5'h0f);
      end
      $display("test normal actions done");
      wb(OFS_CTRL_B, 8'h00, 8'h00);
      wb(OFS_CTRL_A, 8'h00, 8'h00);
      wb(OFS_CMP_B, 8'h80, 8'h00);
      wb(OFS_COUNT, 8'h05, 8'h00);
      wb(OFS_IRQ_STATUS, 8'h07, 8'h00);
      wb(OFS_IRQ_MASK, 8'h01, 8'h00);
      wb(OFS_CTRL_A, 8'he3, 8'h00);
      // buffered: the old compare a value stays active until top
      wb(OFS_CMP_A, 8'h30, 8'h00);
      wb(OFS_CTRL_B, 8'h01, 8'h00);
      repeat (20) @(posedge clk_i);
      look(5'b01011, 5'h1f);
      repeat (260) @(posedge clk_i);
      look(5'b11110, 5'h1f);
      repeat (32) @(posedge clk_i);
      look(5'b11111, 5'h1f);
      repeat (80) @(posedge clk_i);
      look(5'b11011, 5'h1f);
      wb(OFS_IRQ_STATUS, 8'h07, 8'h07);
      wb(OFS_IRQ_STATUS, 8'h07, 8'h00);
      wb(OFS_IRQ_MASK, 8'h00, 8'h00);
      wb(OFS_IRQ_STATUS, 8'h00, 8'h07);
      look(5'h00, 5'h10);
      $display("test fast pwm done");
      wb(OFS_CTRL_B, 8'h00, 8'h00);
      wb(OFS_CTRL_A, 8'h00, 8'h00);
      wb(OFS_CMP_A, 8'h40, 8'h00);
      wb(OFS_COUNT, 8'h00, 8'h00);
      wb(OFS_CTRL_A, 8'hc3, 8'h00);
      wb(OFS_IRQ_STATUS, 8'h07, 8'h00);
      wb(OFS_CTRL_B, 8'h09, 8'h00);
      repeat (80) @(posedge clk_i);
      for (i = 0; i < 200; i++) look(5'h00, 5'h11);
      wb(OFS_IRQ_STATUS, 8'h01, 8'h01);
      $display("test compare at top done");
      wb(OFS_CTRL_B, 8'h00, 8'h00);
      wb(OFS_CTRL_A, 8'h00, 8'h00);
      wb(OFS_CMP_B, 8'h40, 8'h00);
      wb(OFS_COUNT, 8'h00, 8'h00);
      wb(OFS_CTRL_A, 8'hb1, 8'h00);
      wb(OFS_CTRL_B, 8'h01, 8'h00);
      repeat (128) @(posedge clk_i);
      look(5'b01110, 5'h0f);
      repeat (352) @(posedge clk_i);
      look(5'b01011, 5'h0f);
      $display("test phase correct done");
      wb(OFS_CTRL_B, 8'h00, 8'h00);
      wb(OFS_COUNT, 8'h30, 8'h00);
      wb(OFS_CTRL_A, 8'h51, 8'h00);
      wb(OFS_CTRL_B, 8'h01, 8'h00);
      repeat (128) @(posedge clk_i);
      look(5'b00001, 5'h05);
      $display("test reserved toggle done");
      // mode 5: top from compare a, channel a code 01 toggles at each top match
      wb(OFS_CTRL_B, 8'h00, 8'h00);
      wb(OFS_COUNT, 8'h00, 8'h00);
      wb(OFS_IRQ_STATUS, 8'h07, 8'h00);
      wb(OFS_CTRL_B, 8'h09, 8'h00);
      repeat (100) @(posedge clk_i);
      look(5'b00000, 5'h01);
      repeat (100) @(posedge clk_i);
      look(5'b00001, 5'h01);
      wb(OFS_IRQ_STATUS, 8'h01, 8'h01);
      $display("test pwm toggle done");
      end_sim();
   end
endmodule
